// ### bench/cecwv_node_model.sv
// Model of another node on the shared line: sends low pulses and decodes bits.
`timescale 1ns/100ps
module cecwv_node_model (
  input wire mclk,
  input wire rst_n,
  input wire fs_tick,
  input wire line,
  input wire go,
  input wire [7:0] len,
  output reg oe,
  output reg [8:0] rx_bits
);
  // ****
  // Line driver and decoder
  // ****
  reg [7:0] tx_cnt_reg;
  reg [7:0] low_cnt_reg;
  reg line_q;
  always @(posedge mclk) begin
    if (!rst_n) begin
      oe <= 1'b0;
      tx_cnt_reg <= 8'h00;
      low_cnt_reg <= 8'h00;
      rx_bits <= 9'h000;
      line_q <= 1'b1;
    end else begin
      line_q <= line;
      if (go) begin
        oe <= 1'b1;
        tx_cnt_reg <= len;
      end else if (oe && fs_tick) begin
        tx_cnt_reg <= tx_cnt_reg - 8'h01;
        if (tx_cnt_reg == 8'h01) oe <= 1'b0;
      end
      if (!line && fs_tick) low_cnt_reg <= low_cnt_reg + 8'h01;
      // Long lows are start bits and carry no data; short low means one.
      if (line && !line_q) begin
        if (low_cnt_reg < 8'h64) rx_bits <= {rx_bits[7:0], low_cnt_reg < 8'h23};
        low_cnt_reg <= 8'h00;
      end
    end
  end
endmodule

// ### bench/cecwv_top_sva.sv
// Port-level assertions for the waveform check and transmit start block.
`timescale 1ns/100ps
module cecwv_top_sva #(
  parameter CNT_W = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire fs_tick,
  input wire cec_in,
  input wire cec_out,
  input wire cec_oe,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire irq
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Longest low drive is the start bit; one tick of phase slack is allowed.
  reg [7:0] low_cnt_reg;
  always @(posedge mclk) begin
    if (!rst_n || !cec_oe) begin
      low_cnt_reg <= 8'h00;
    end else if (fs_tick) begin
      low_cnt_reg <= low_cnt_reg + 8'h01;
    end
  end
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack missing");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  irq_fall_a: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2))
    else $error("irq dropped without write");
  drive_low_a: assert property (cec_oe |-> !cec_out) else $error("driven high");
  tx_low_bound_a: assert property (low_cnt_reg <= 8'h7A) else $error("low too long");
  start_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04 |->
    wb_dat_o[31:2] == 30'h0 && !wb_dat_o[0]) else $error("start reg bits");
  ctrl_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |->
    (wb_dat_o & 32'hFF8888FE) == 32'h0) else $error("ctrl reg bits");
  buf_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h08 |->
    wb_dat_o[31:9] == 23'h0) else $error("buf reg bits");
  start_rise_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0] && wb_dat_i[0]
    && !cec_oe |=> ##[0:3] cec_oe) else $error("no start");
  abort_stop_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0] && !wb_dat_i[0]
    |=> ##[0:3] !cec_oe) else $error("no abort");
  cover property ($rose(cec_oe));
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule
bind cecwv_top cecwv_top_sva #(.CNT_W(CNT_W)) i_cecwv_top_sva (.mclk(mclk), .rst_n(rst_n), .fs_tick(fs_tick),
  .cec_in(cec_in), .cec_out(cec_out), .cec_oe(cec_oe), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .irq(irq));

// ### bench/cecwv_top_tb.sv
// Self-checking bench for the waveform check and transmit start block.
`timescale 1ns/100ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: %s", $time, m); end end
module cecwv_top_tb;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg fs_tick = 1'b0;
  reg cyc = 1'b0;
  reg stb = 1'b0;
  reg we = 1'b0;
  reg go = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] dat = 32'h0;
  reg [7:0] plen = 8'h00;
  reg [1:0] div = 2'h0;
  reg [31:0] rd;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, irq, cec_out, cec_oe, node_oe, line;
  wire [8:0] rx_bits;
  int fail_count = 0;
  int num_checks = 0;
  reg [31:0] wctl [0:11] = '{32'h1, 32'h701, 32'h1, 32'h1, 32'h1, 32'h7001, 32'h1, 32'h70001, 32'h1,
    32'h1, 32'h700001, 32'h0};
  reg [7:0] wlen [0:11] = '{8'h08, 8'h08, 8'h14, 8'h23, 8'h1E, 8'h1E, 8'h28, 8'h28, 8'h31, 8'h3C, 8'h3C, 8'h08};
  reg [11:0] werr = 12'h259;
  // ****
  // Clock, fs strobe and open-drain line
  // ****
  assign line = ~(cec_oe | node_oe);
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    div <= div + 2'h1;
    fs_tick <= (div == 2'h3);
  end
  cecwv_top #(.CNT_W(8)) i_cecwv_top (.mclk(mclk), .rst_n(rst_n), .fs_tick(fs_tick), .cec_in(line),
    .cec_out(cec_out), .cec_oe(cec_oe), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
  cecwv_node_model i_cecwv_node_model (.mclk(mclk), .rst_n(rst_n), .fs_tick(fs_tick), .line(line), .go(go),
    .len(plen), .oe(node_oe), .rx_bits(rx_bits));
  // ****
  // Tasks
  // ****
  task summarize;
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      $display("Error %0t: bus timeout", $time);
      summarize();
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task rdc(input [7:0] a);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  task regs_check;
    rdc(8'h00); `CHK(rd, 32'h0, "ctrl reset")
    rdc(8'h04); `CHK(rd, 32'h0, "start reset")
    rdc(8'h08); `CHK(rd, 32'h0, "buf reset")
    rdc(8'h40); `CHK(rd, 32'h0, "unmapped read")
    wr(8'h00, 32'hFFFFFFFF);
    rdc(8'h00); `CHK(rd, 32'h00777701, "ctrl fields")
    wr(8'h08, 32'hFFFFFFFF);
    wb(1'b1, 8'h08, 32'h0, 4'h1);
    rdc(8'h08); `CHK(rd, 32'h100, "buf lanes")
  endtask
  task wave_check;
    wr(8'h18, 32'h2);
    for (int i = 0; i < 12; i++) begin
      wr(8'h10, 32'h0);
      rdc(8'h10); `CHK(rd[0], 1'b0, "rx stop")
      wr(8'h00, wctl[i]);
      wr(8'h10, 32'h1);
      go <= 1'b1;
      plen <= wlen[i];
      @(posedge mclk);
      go <= 1'b0;
      // Waits past the latest zero limit with its largest code.
      repeat (300) @(posedge mclk);
      rdc(8'h14); `CHK(rd[1], werr[i], "wave flag")
      `CHK(irq, werr[i], "rx irq")
      wr(8'h14, 32'h2);
    end
  endtask
  task tx_run;
    int n;
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h1A5);
    wr(8'h0C, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h04, 32'h1);
    rdc(8'h04); `CHK(rd, 32'h2, "busy")
    n = 0;
    do begin
      rdc(8'h14);
      n++;
    end while (rd[0] !== 1'b1 && n < 3000);
    `CHK(rd[0], 1'b1, "tx done")
    if (rd[0] !== 1'b1) summarize();
    rdc(8'h04); `CHK(rd, 32'h0, "idle")
    `CHK(rx_bits, 9'h14B, "sent bits")
    `CHK(irq, 1'b0, "masked irq")
    wr(8'h18, 32'h1);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b1, "unmasked irq")
    wr(8'h14, 32'h1);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0, "cleared irq")
  endtask
  task tx_abort;
    wr(8'h04, 32'h1);
    repeat (40) @(posedge mclk);
    `CHK(cec_oe, 1'b1, "start driven")
    `CHK(cec_out, 1'b0, "start level")
    wr(8'h04, 32'h0);
    repeat (4) @(posedge mclk);
    `CHK(cec_oe, 1'b0, "abort released")
    rdc(8'h14); `CHK(rd[0], 1'b0, "abort no done")
    rdc(8'h04); `CHK(rd, 32'h0, "abort idle")
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    regs_check();
    wave_check();
    tx_run();
    tx_abort();
    summarize();
  end
endmodule

// ### core/cecwv_consts.vh
// Constants shared by the waveform check and transmit start block.
`ifndef CECWV_CONSTS_VH
`define CECWV_CONSTS_VH
`define CECWV_OFS_RXWAV 8'h00
`define CECWV_OFS_TXSTART 8'h04
`define CECWV_OFS_TXBUF 8'h08
`define CECWV_OFS_TXTIME 8'h0C
`define CECWV_OFS_RXEN 8'h10
`define CECWV_OFS_IRQ_STAT 8'h14
`define CECWV_OFS_IRQ_MASK 8'h18
`define CECWV_BIT_WAVEN 0
`define CECWV_POS_ONE_EARLY 8
`define CECWV_POS_ONE_LATE 12
`define CECWV_POS_ZERO_EARLY 16
`define CECWV_POS_ZERO_LATE 20
`define CECWV_BIT_TXSTART 0
`define CECWV_BIT_TXBUSY 1
`define CECWV_BIT_EOM 8
`define CECWV_BASE_ONE_EARLY 8'h0D
`define CECWV_BASE_ONE_LATE 8'h1A
`define CECWV_BASE_ZERO_EARLY 8'h2B
`define CECWV_BASE_ZERO_LATE 8'h38
`define CECWV_TX_ONE_RISE 8'h14
`define CECWV_TX_ZERO_RISE 8'h31
`define CECWV_TX_BIT_PERIOD 8'h4B
`define CECWV_TX_START_RISE 8'h79
`define CECWV_TX_START_PERIOD 8'h93
`define CECWV_IRQ_TXDONE 0
`define CECWV_IRQ_RXERR 1
`define CECWV_IRQ_TXERR 2
`define CECWV_RST_ZERO 32'h00000000
`endif

// ### core/cecwv_sync.v
// Two-stage synchroniser with a registered falling and rising edge detector.
`timescale 1ns/100ps
module cecwv_sync (
  input wire mclk,
  input wire rst_n,
  input wire din,
  output reg dout,
  output reg fall,
  output reg rise
);
  reg meta_reg;
  reg stage_reg;
  always @(posedge mclk) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      stage_reg <= 1'b1;
      dout <= 1'b1;
      fall <= 1'b0;
      rise <= 1'b0;
    end else begin
      meta_reg <= din;
      stage_reg <= meta_reg;
      dout <= stage_reg;
      fall <= dout & ~stage_reg;
      rise <= ~dout & stage_reg;
    end
  end
endmodule

// ### core/cecwv_top.v
// Receive waveform checker, transmit buffer and transmit start logic with a Wishbone slave.
`timescale 1ns/100ps
`include "cecwv_consts.vh"
module cecwv_top #(
  parameter CNT_W = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire fs_tick,
  input wire cec_in,
  output reg cec_out,
  output reg cec_oe,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg irq
);
  // ************************************************
  // Registers and bus slave
  // ************************************************
  localparam TX_IDLE = 2'b00;
  localparam TX_START = 2'b01;
  localparam TX_BIT = 2'b10;
  reg waveform_check_enable;
  reg [2:0] one_early_limit;
  reg [2:0] one_late_limit;
  reg [2:0] zero_early_limit;
  reg [2:0] zero_late_limit;
  reg tx_start_control;
  reg tx_in_progress;
  reg [7:0] tx_data_byte;
  reg tx_end_of_message;
  reg [31:0] tx_timing_control;
  reg rx_enable_control;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg [2:0] irq_set;
  wire wb_req;
  wire wb_commit;
  wire wb_wr;
  wire hit_txstart;
  wire hit_irqstat;
  wire line_lvl;
  wire line_fall;
  wire line_rise;
  reg [31:0] rd_word;
  // Ack is registered, so a request stands for two edges; writes land only at the second, where the master
  // samples ack, and are never applied twice.
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_commit = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
  assign wb_wr = wb_commit & wb_sel_i[0];
  assign hit_txstart = wb_adr_i == `CECWV_OFS_TXSTART;
  assign hit_irqstat = wb_adr_i == `CECWV_OFS_IRQ_STAT;
  // ************************************************
  // Line synchroniser
  // ************************************************
  // Both edges pass the same chain of flops, so measured low times carry no skew from it.
  cecwv_sync u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(cec_in),
    .dout(line_lvl),
    .fall(line_fall),
    .rise(line_rise)
  );
  // ************************************************
  // Limit arithmetic
  // ************************************************
  function [7:0] lim_add;
    input [7:0] base;
    input [2:0] code;
    begin
      lim_add = base + {5'h00, code};
    end
  endfunction
  function [7:0] lim_sub;
    input [7:0] base;
    input [2:0] code;
    begin
      lim_sub = base - {5'h00, code};
    end
  endfunction
  // ************************************************
  // Read data
  // ************************************************
  // Reads have no side effects, so the mux may be sampled on any request edge.
  // Unmapped offsets read zero and writes to them are dropped.
  always @* begin
    rd_word = `CECWV_RST_ZERO;
    case (wb_adr_i)
      `CECWV_OFS_RXWAV: rd_word = {9'h000, zero_late_limit, 1'b0, zero_early_limit, 1'b0, one_late_limit, 1'b0,
        one_early_limit, 7'h00, waveform_check_enable};
      `CECWV_OFS_TXSTART: rd_word = {30'h00000000, tx_in_progress, 1'b0};
      `CECWV_OFS_TXBUF: rd_word = {23'h000000, tx_end_of_message, tx_data_byte};
      `CECWV_OFS_TXTIME: rd_word = tx_timing_control;
      `CECWV_OFS_RXEN: rd_word = {31'h00000000, rx_enable_control};
      `CECWV_OFS_IRQ_STAT: rd_word = {29'h00000000, irq_stat_reg};
      `CECWV_OFS_IRQ_MASK: rd_word = {29'h00000000, irq_mask_reg};
      default: rd_word = `CECWV_RST_ZERO;
    endcase
  end
  // ************************************************
  // Register writes
  // ************************************************
  // Software is expected to stop reception before changing limits, so no shadowing is done.
  always @(posedge mclk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `CECWV_RST_ZERO;
      waveform_check_enable <= 1'b0;
      one_early_limit <= 3'h0;
      one_late_limit <= 3'h0;
      zero_early_limit <= 3'h0;
      zero_late_limit <= 3'h0;
      tx_data_byte <= 8'h00;
      tx_end_of_message <= 1'b0;
      tx_timing_control <= `CECWV_RST_ZERO;
      rx_enable_control <= 1'b0;
      irq_mask_reg <= 3'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_word;
      end
      if (wb_commit) begin
        case (wb_adr_i)
          `CECWV_OFS_RXWAV: begin
            if (wb_sel_i[0]) waveform_check_enable <= wb_dat_i[`CECWV_BIT_WAVEN];
            if (wb_sel_i[1]) begin
              one_early_limit <= wb_dat_i[`CECWV_POS_ONE_EARLY +: 3];
              one_late_limit <= wb_dat_i[`CECWV_POS_ONE_LATE +: 3];
            end
            if (wb_sel_i[2]) begin
              zero_early_limit <= wb_dat_i[`CECWV_POS_ZERO_EARLY +: 3];
              zero_late_limit <= wb_dat_i[`CECWV_POS_ZERO_LATE +: 3];
            end
          end
          `CECWV_OFS_TXBUF: begin
            if (wb_sel_i[0]) tx_data_byte <= wb_dat_i[7:0];
            if (wb_sel_i[1]) tx_end_of_message <= wb_dat_i[`CECWV_BIT_EOM];
          end
          `CECWV_OFS_TXTIME: tx_timing_control <= wb_dat_i;
          `CECWV_OFS_RXEN: if (wb_sel_i[0]) rx_enable_control <= wb_dat_i[0];
          `CECWV_OFS_IRQ_MASK: if (wb_sel_i[0]) irq_mask_reg <= wb_dat_i[2:0];
          default: ;
        endcase
      end
    end
  end
  // ************************************************
  // Receive waveform check
  // ************************************************
  reg [CNT_W-1:0] rx_cnt_reg;
  reg rx_low_reg;
  wire [7:0] one_early_cyc;
  wire [7:0] one_late_cyc;
  wire [7:0] zero_early_cyc;
  wire [7:0] zero_late_cyc;
  wire chk_on;
  wire [7:0] rx_cnt8;
  assign one_early_cyc = lim_sub(`CECWV_BASE_ONE_EARLY, one_early_limit);
  assign one_late_cyc = lim_add(`CECWV_BASE_ONE_LATE, one_late_limit);
  assign zero_early_cyc = lim_sub(`CECWV_BASE_ZERO_EARLY, zero_early_limit);
  assign zero_late_cyc = lim_add(`CECWV_BASE_ZERO_LATE, zero_late_limit);
  assign chk_on = waveform_check_enable & rx_enable_control & ~tx_in_progress;
  assign rx_cnt8 = rx_cnt_reg[7:0];
  // ************************************************
  // Error decode
  // ************************************************
  wire err_early;
  wire err_gap;
  wire err_late;
  wire rx_err;
  // Each check needs an open low period, so one received bit raises at most one error.
  assign err_early = line_rise && rx_cnt8 < one_early_cyc;
  assign err_gap = line_rise && rx_cnt8 > one_late_cyc && rx_cnt8 < zero_early_cyc;
  assign err_late = !line_rise && rx_cnt8 == zero_late_cyc;
  assign rx_err = chk_on && rx_low_reg && (err_early || err_gap || err_late);
  // ************************************************
  // Low time counter
  // ************************************************
  // The counter saturates so a stuck-low line reports once, not every wrap.
  always @(posedge mclk) begin
    if (!rst_n) begin
      rx_cnt_reg <= {CNT_W{1'b0}};
      rx_low_reg <= 1'b0;
    end else if (line_fall) begin
      rx_cnt_reg <= {CNT_W{1'b0}};
      rx_low_reg <= 1'b1;
    end else if (line_rise || rx_err) begin
      rx_low_reg <= 1'b0;
    end else if (rx_low_reg && fs_tick && rx_cnt_reg != {CNT_W{1'b1}}) begin
      rx_cnt_reg <= rx_cnt_reg + 1'b1;
    end
  end
  // ************************************************
  // Transmitter
  // ************************************************
  reg [1:0] tx_state;
  reg [7:0] tx_cnt_reg;
  reg [8:0] tx_shift_reg;
  reg [3:0] tx_bits_reg;
  reg tx_done;
  reg tx_abort;
  wire tx_go;
  wire tx_stop;
  wire [7:0] tx_rise;
  // A start write is honoured only from idle; a busy transmitter ignores it.
  assign tx_go = wb_wr && hit_txstart && wb_dat_i[`CECWV_BIT_TXSTART];
  assign tx_stop = wb_wr && hit_txstart && !wb_dat_i[`CECWV_BIT_TXSTART];
  assign tx_rise = tx_shift_reg[8] ? `CECWV_TX_ONE_RISE : `CECWV_TX_ZERO_RISE;
  // ************************************************
  // Bit sequencer
  // ************************************************
  always @(posedge mclk) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
      tx_cnt_reg <= 8'h00;
      tx_shift_reg <= 9'h000;
      tx_bits_reg <= 4'h0;
      tx_start_control <= 1'b0;
      tx_in_progress <= 1'b0;
      tx_done <= 1'b0;
      tx_abort <= 1'b0;
      cec_out <= 1'b1;
      cec_oe <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      tx_abort <= 1'b0;
      // The control bit gates the sequencer; a stop write releases the line at once.
      if (tx_stop || (tx_state != TX_IDLE && !tx_start_control)) begin
        tx_start_control <= 1'b0;
        tx_state <= TX_IDLE;
        tx_in_progress <= 1'b0;
        cec_oe <= 1'b0;
      end else begin
        case (tx_state)
          TX_IDLE: begin
            if (tx_go) begin
              tx_start_control <= 1'b1;
              tx_in_progress <= 1'b1;
              tx_shift_reg <= {tx_data_byte, tx_end_of_message};
              tx_bits_reg <= 4'h9;
              tx_cnt_reg <= 8'h00;
              tx_state <= TX_START;
              cec_oe <= 1'b1;
              cec_out <= 1'b0;
            end
          end
          TX_START: begin
            // Our own pull-down needs a few ticks to come back through the synchroniser; a high line
            // after that means the pin is not following the drive.
            if (cec_oe && !cec_out && line_lvl && tx_cnt_reg > 8'h02 && !tx_abort) begin
              tx_abort <= 1'b1;
            end else if (fs_tick) begin
              tx_cnt_reg <= tx_cnt_reg + 8'h01;
              if (tx_cnt_reg == `CECWV_TX_START_RISE) cec_oe <= 1'b0;
              if (tx_cnt_reg == `CECWV_TX_START_PERIOD) begin
                tx_cnt_reg <= 8'h00;
                tx_state <= TX_BIT;
                cec_oe <= 1'b1;
              end
            end
          end
          TX_BIT: begin
            if (fs_tick) begin
              tx_cnt_reg <= tx_cnt_reg + 8'h01;
              if (tx_cnt_reg == tx_rise) cec_oe <= 1'b0;
              if (tx_cnt_reg == `CECWV_TX_BIT_PERIOD) begin
                tx_cnt_reg <= 8'h00;
                tx_shift_reg <= {tx_shift_reg[7:0], 1'b0};
                tx_bits_reg <= tx_bits_reg - 4'h1;
                if (tx_bits_reg == 4'h1) begin
                  tx_done <= 1'b1;
                  tx_state <= TX_IDLE;
                end else begin
                  cec_oe <= 1'b1;
                end
              end
            end
          end
          default: tx_state <= TX_IDLE;
        endcase
        if (tx_done || tx_abort) begin
          tx_start_control <= 1'b0;
          tx_in_progress <= 1'b0;
          tx_state <= TX_IDLE;
          cec_oe <= 1'b0;
        end
      end
    end
  end
  // ************************************************
  // Interrupts
  // ************************************************
  always @* begin
    irq_set = 3'h0;
    irq_set[`CECWV_IRQ_TXDONE] = tx_done;
    irq_set[`CECWV_IRQ_RXERR] = rx_err;
    irq_set[`CECWV_IRQ_TXERR] = tx_abort;
  end
  // ************************************************
  // Status and output
  // ************************************************
  // A set in the same cycle as a write-one clear wins, so no event is lost.
  // The output lags status by one edge so that it comes straight from a flop.
  always @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      if (wb_wr && hit_irqstat) begin
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[2:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
endmodule
